// File: adc_seq_cfg.svh
// Offsets, field positions, reset values and timing counts of the sequencer.
// Assumes a 100 MHz register clock and a byte-addressed Wishbone bus.
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
// ****************
// Register offsets
// ****************
`define OFS_CTRL1   8'h00
`define OFS_CTRL2   8'h04
`define OFS_CTRL3   8'h08
`define OFS_STS     8'h0C
`define OFS_JSEQ    8'h10
`define OFS_RSEQ1   8'h14
`define OFS_RSEQ2   8'h18
`define OFS_RSEQ3   8'h1C
`define OFS_WDGHI   8'h20
`define OFS_WDGLO   8'h24
`define OFS_DAT     8'h28
`define OFS_JDAT0   8'h2C
`define OFS_JDAT3   8'h38
// ****************
// Field positions
// ****************
`define C1_GCH_LSB  0
`define C1_REIE     5
`define C1_GIE      6
`define C1_IEIE     7
`define C1_GSGL     9
`define C1_GIEN     22
`define C1_GREN     23
`define C2_ON       0
`define C2_RPT      1
`define C2_DIV_LSB  8
`define C2_PLL      12
`define C2_ISRC_LSB 16
`define C2_IEXT     19
`define C2_RSRC_LSB 20
`define C2_REXT     23
`define C3_RDY      0
`define C3_PDD      1
`define C3_DEEP     2
`define C3_CAL      3
`define ST_TRIP     0
`define ST_REND     1
`define ST_IEND     2
`define RSEQ_LEN_LSB 20
`define JSEQ_LEN_LSB 20
// ****************
// Write masks and reset values
// ****************
`define C1_WMASK    32'h00C0_02FF
`define C2_WMASK    32'h00FF_1F03
`define C3_WMASK    32'h0000_0004
`define RSEQ1_WMASK 32'h00FF_FFFF
`define RSEQ_WMASK  32'h3FFF_FFFF
`define JSEQ_WMASK  32'h003F_FFFF
`define THR_WMASK   32'h0000_0FFF
`define WDGHI_RST   32'h0000_0FFF
`define ZERO_RST    32'h0000_0000
// ****************
// Fixed internal channels
// ****************
`define CH_VREFINT  5'h00
`define CH_OP1      5'h03
`define CH_OP2      5'h07
`define CH_TEMP     5'h11
`define CH_VREFBUF  5'h12
// ****************
// Timing
// ****************
`define CLK_PERIOD_NS  10
`define TIMING_TICK_NS 1000
`define TICK_CYCLES    (`TIMING_TICK_NS / `CLK_PERIOD_NS)
`define CLK_MHZ        (1000 / `CLK_PERIOD_NS)
`define MAX_WORK_MHZ   72
`define MIN_SYNC_DIV   ((`CLK_MHZ + `MAX_WORK_MHZ - 1) / `MAX_WORK_MHZ)
`endif

// File: adc_seq_pkg.sv
// Types shared by the sequencer and the converter core model.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_seq_pkg;
  typedef enum logic [2:0] {PWR_OFF, PWR_STAB, PWR_IDLE, PWR_CONV, PWR_DOWN} pwr_state_t;
  typedef struct packed {
    logic       start;
    logic       injected;
    logic [4:0] channel;
  } conv_req_t;
  typedef struct packed {
    logic        done;
    logic [11:0] data;
  } conv_res_t;
endpackage

// File: inj_result_mem.sv
// Small result store with registered read data.
// Assumes one write and one read port on the same clock.
module inj_result_mem #(
  parameter int W     = 16,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);
  logic [W-1:0] mem [DEPTH];
  initial
  begin
    if (DEPTH > (1 << AW))
      $error("inj_result_mem: depth exceeds address range");
  end
  always_ff @(posedge clk_i)
  begin
    if (we_i)
      mem[waddr_i] <= wdata_i;
    rdata_o <= mem[raddr_i];
  end
endmodule

// File: adc_sequencer_control.sv
// Converter sequencer: power handshake, working clock, regular and injected
// sequences, end flags, results and threshold guard, behind a Wishbone slave.
// Assumes the converter core answers each start with one done pulse on clk_i.
`include "adc_seq_cfg.svh"
module adc_sequencer_control #(
  parameter int STAB_US  = 2,
  parameter int PDOWN_US = 2,
  parameter int NTRIG    = 8
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [7:0]             adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic      [31:0]            dat_o,
  output logic                        ack_o,
  input  wire logic [NTRIG-1:0]       reg_trig_i,
  input  wire logic [NTRIG-1:0]       inj_trig_i,
  input  wire logic                   pll_clk_i,
  input  wire adc_seq_pkg::conv_res_t conv_res_i,
  output adc_seq_pkg::conv_req_t      conv_req_o,
  output logic                        work_tick_o,
  output logic                        power_on_o,
  output logic                        deep_sleep_o,
  output logic                        irq_o
);
  localparam int TICK_P = `TICK_CYCLES;
  localparam int PD_MAX = (PDOWN_US + 1) * TICK_P;
  initial
  begin
    if (NTRIG != 8 || STAB_US < 1 || PDOWN_US < 1 || STAB_US > 65535 || PDOWN_US > 65535)
      $error("adc_sequencer_control: unsupported parameter value");
  end

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r & msk;
  endfunction

  function automatic logic [8:0] div_ratio(input logic [3:0] code, input logic pll);
    logic [8:0] r;
    unique case (code)
      4'h0: r = 9'h001;
      4'h1: r = 9'h002;
      4'h2: r = 9'h004;
      4'h3: r = 9'h006;
      4'h4: r = 9'h008;
      4'h5: r = 9'h00A;
      4'h6: r = 9'h00C;
      4'h7: r = 9'h010;
      4'h8: r = 9'h020;
      4'h9: r = 9'h040;
      4'hA: r = 9'h080;
      default: r = 9'h100;
    endcase
    if (!pll && code > 4'h8)
      r = 9'h020;
    if (!pll && r < 9'(`MIN_SYNC_DIV))
      r = 9'(`MIN_SYNC_DIV);
    return r;
  endfunction

  function automatic logic [4:0] chan_at(input logic [79:0] v, input logic [3:0] i);
    logic [4:0] c;
    c = v[5*i +: 5];
    return (c > `CH_VREFBUF) ? `CH_VREFINT : c;
  endfunction

  // ****************
  // Registers and state
  // ****************
  logic [31:0]             ctrl1, ctrl2, ctrl3, jseq, rseq1, rseq2, rseq3, wdghi, wdglo;
  logic [15:0]             dat_reg;
  logic [2:0]              flags;
  logic                    pend, cal_valid, pd_done;
  adc_seq_pkg::pwr_state_t st;
  logic [15:0]             us_cnt;
  logic [6:0]              tcnt;
  logic                    tick1m;
  logic [NTRIG-1:0]        r_s1, r_s2, r_s3, i_s1, i_s2, i_s3;
  logic                    p_s1, p_s2, p_s3;
  logic [8:0]              divcnt;
  logic                    reg_pend, inj_pend, need_start, grp_inj;
  logic [3:0]              pos;
  logic [15:0]             mem_rdata;

  wire logic        wr       = pend && we_i;
  wire logic        on_wr    = wr && adr_i == `OFS_CTRL2 && sel_i[0];
  wire logic        new_on   = dat_i[`C2_ON];
  wire logic        off_req  = on_wr && !new_on;
  wire logic        powered  = st == adc_seq_pkg::PWR_IDLE || st == adc_seq_pkg::PWR_CONV;
  wire logic        pll_sel  = ctrl2[`C2_PLL];
  wire logic [8:0]  ratio    = div_ratio(ctrl2[`C2_DIV_LSB +: 4], pll_sel);
  wire logic        p_rise   = p_s2 && !p_s3;
  wire logic        adv      = pll_sel ? p_rise : 1'b1;
  wire logic        wtick    = adv && divcnt >= ratio - 9'h001;
  wire logic [2:0]  rsrc     = ctrl2[`C2_RSRC_LSB +: 3];
  wire logic [2:0]  isrc     = ctrl2[`C2_ISRC_LSB +: 3];
  wire logic        r_edge   = ctrl2[`C2_REXT] && r_s2[rsrc] && !r_s3[rsrc];
  wire logic        i_edge   = ctrl2[`C2_IEXT] && i_s2[isrc] && !i_s3[isrc];
  wire logic [3:0]  rlen     = rseq1[`RSEQ_LEN_LSB +: 4];
  wire logic [3:0]  injected_seq_count     = {2'b00, jseq[`JSEQ_LEN_LSB +: 2]};
  wire logic [3:0]  cur_len  = grp_inj ? injected_seq_count : rlen;
  wire logic [79:0] rchans   = {rseq1[19:0], rseq2[29:0], rseq3[29:0]};
  wire logic [79:0] jchans   = {60'h0, jseq[19:0]};
  wire logic        done     = st == adc_seq_pkg::PWR_CONV && conv_res_i.done;
  wire logic        seq_end  = done && pos == cur_len;
  wire logic        launch   = st == adc_seq_pkg::PWR_IDLE && (inj_pend || reg_pend) && !off_req;
  wire logic [11:0] raw      = conv_res_i.data;
  wire logic        sw_start = on_wr && new_on && ctrl2[`C2_ON] && powered;

  // ****************
  // Wishbone slave
  // ****************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend  <= 1'b0;
      ack_o <= 1'b0;
      dat_o <= `ZERO_RST;
    end
    else
    begin
      pend  <= cyc_i && stb_i && !pend && !ack_o;
      ack_o <= pend;
      if (pend && !we_i)
      begin
        unique case (adr_i)
          `OFS_CTRL1: dat_o <= ctrl1;
          `OFS_CTRL2: dat_o <= ctrl2;
          `OFS_CTRL3: dat_o <= ctrl3 | {28'h0, cal_valid, 1'b0, pd_done, powered};
          `OFS_STS:   dat_o <= {29'h0, flags};
          `OFS_JSEQ:  dat_o <= jseq;
          `OFS_RSEQ1: dat_o <= rseq1;
          `OFS_RSEQ2: dat_o <= rseq2;
          `OFS_RSEQ3: dat_o <= rseq3;
          `OFS_WDGHI: dat_o <= wdghi;
          `OFS_WDGLO: dat_o <= wdglo;
          `OFS_DAT:   dat_o <= {16'h0, dat_reg};
          8'h2C, 8'h30, 8'h34, `OFS_JDAT3: dat_o <= {16'h0, mem_rdata};
          default:    dat_o <= `ZERO_RST;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl1 <= `ZERO_RST;
      ctrl2 <= `ZERO_RST;
      ctrl3 <= `ZERO_RST;
      jseq  <= `ZERO_RST;
      rseq1 <= `ZERO_RST;
      rseq2 <= `ZERO_RST;
      rseq3 <= `ZERO_RST;
      wdghi <= `WDGHI_RST;
      wdglo <= `ZERO_RST;
    end
    else if (wr)
    begin
      unique case (adr_i)
        `OFS_CTRL1: ctrl1 <= merge(ctrl1, dat_i, sel_i, `C1_WMASK);
        `OFS_CTRL2: ctrl2 <= merge(ctrl2, dat_i, sel_i, `C2_WMASK);
        `OFS_CTRL3: ctrl3 <= merge(ctrl3, dat_i, sel_i, `C3_WMASK);
        `OFS_JSEQ:  jseq  <= merge(jseq, dat_i, sel_i, `JSEQ_WMASK);
        `OFS_RSEQ1: rseq1 <= merge(rseq1, dat_i, sel_i, `RSEQ1_WMASK);
        `OFS_RSEQ2: rseq2 <= merge(rseq2, dat_i, sel_i, `RSEQ_WMASK);
        `OFS_RSEQ3: rseq3 <= merge(rseq3, dat_i, sel_i, `RSEQ_WMASK);
        `OFS_WDGHI: wdghi <= merge(wdghi, dat_i, sel_i, `THR_WMASK);
        `OFS_WDGLO: wdglo <= merge(wdglo, dat_i, sel_i, `THR_WMASK);
        default:    ;
      endcase
    end
  end

  // ****************
  // Clocks and input synchronisers
  // ****************
  // 1 MHz timing tick
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tcnt   <= 7'h00;
      tick1m <= 1'b0;
    end
    else
    begin
      tcnt   <= (tcnt == 7'(TICK_P - 1)) ? 7'h00 : tcnt + 7'h01;
      tick1m <= tcnt == 7'(TICK_P - 1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {r_s1, r_s2, r_s3, i_s1, i_s2, i_s3} <= '0;
      {p_s1, p_s2, p_s3}                   <= 3'h0;
    end
    else
    begin
      {r_s3, r_s2, r_s1} <= {r_s2, r_s1, reg_trig_i};
      {i_s3, i_s2, i_s1} <= {i_s2, i_s1, inj_trig_i};
      {p_s3, p_s2, p_s1} <= {p_s2, p_s1, pll_clk_i};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || (!pll_sel && st != adc_seq_pkg::PWR_CONV))
      divcnt <= 9'h000;
    else if (adv)
      divcnt <= wtick ? 9'h000 : divcnt + 9'h001;
  end

  // ****************
  // Power sequencing
  // ****************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st        <= adc_seq_pkg::PWR_OFF;
      us_cnt    <= 16'h0000;
      pd_done   <= 1'b0;
      cal_valid <= 1'b0;
    end
    else
    begin
      if (wr && adr_i == `OFS_CTRL3 && sel_i[0] && dat_i[`C3_CAL])
        cal_valid <= 1'b1;
      unique case (st)
        adc_seq_pkg::PWR_OFF:
          if (on_wr && new_on)
          begin
            st      <= adc_seq_pkg::PWR_STAB;
            us_cnt  <= 16'h0000;
            pd_done <= 1'b0;
          end
        adc_seq_pkg::PWR_STAB:
          if (off_req)
          begin
            st     <= adc_seq_pkg::PWR_DOWN;
            us_cnt <= 16'h0000;
          end
          else if (tick1m)
          begin
            us_cnt <= us_cnt + 16'h0001;
            if (us_cnt == 16'(STAB_US - 1))
              st <= adc_seq_pkg::PWR_IDLE;
          end
        adc_seq_pkg::PWR_IDLE, adc_seq_pkg::PWR_CONV:
          // clearing on stops and powers down
          if (off_req)
          begin
            st     <= adc_seq_pkg::PWR_DOWN;
            us_cnt <= 16'h0000;
          end
          else if (launch)
            st <= adc_seq_pkg::PWR_CONV;
          else if (seq_end)
            st <= adc_seq_pkg::PWR_IDLE;
        adc_seq_pkg::PWR_DOWN:
          if (tick1m)
          begin
            us_cnt <= us_cnt + 16'h0001;
            if (us_cnt == 16'(PDOWN_US - 1))
            begin
              st      <= adc_seq_pkg::PWR_OFF;
              pd_done <= 1'b1;
              if (ctrl3[`C3_DEEP])
                cal_valid <= 1'b0;
            end
          end
      endcase
    end
  end

  // ****************
  // Sequencing
  // ****************
  always_ff @(posedge clk_i)
  begin
    if (rst_i || st == adc_seq_pkg::PWR_DOWN || st == adc_seq_pkg::PWR_OFF)
    begin
      reg_pend   <= 1'b0;
      inj_pend   <= 1'b0;
      need_start <= 1'b0;
      grp_inj    <= 1'b0;
      pos        <= 4'h0;
      conv_req_o <= '0;
    end
    else
    begin
      reg_pend <= (reg_pend && !(launch && !inj_pend))
                  || sw_start || (powered && r_edge)
                  || (seq_end && !grp_inj && ctrl2[`C2_RPT]);
      inj_pend <= (inj_pend && !launch) || (powered && i_edge);
      conv_req_o.start <= st == adc_seq_pkg::PWR_CONV && need_start && wtick;
      if (launch)
      begin
        grp_inj    <= inj_pend;
        pos        <= 4'h0;
        need_start <= 1'b1;
      end
      else if (st == adc_seq_pkg::PWR_CONV && need_start && wtick)
        need_start <= 1'b0;
      else if (done && !seq_end)
      begin
        pos        <= pos + 4'h1;
        need_start <= 1'b1;
      end
      conv_req_o.injected <= grp_inj;
      conv_req_o.channel  <= grp_inj ? chan_at(jchans, pos) : chan_at(rchans, pos);
    end
  end

  // ****************
  // Results, flags and guard
  // ****************
  // raw value against thresholds
  wire logic g_grp = grp_inj ? ctrl1[`C1_GIEN] : ctrl1[`C1_GREN];
  wire logic g_ch  = !ctrl1[`C1_GSGL] || conv_req_o.channel == ctrl1[`C1_GCH_LSB +: 5];
  wire logic g_out = raw > wdghi[11:0] || raw < wdglo[11:0];
  wire logic trip  = done && g_grp && g_ch && g_out;
  wire logic [2:0] set_f = {done && grp_inj, done && !grp_inj, trip};
  wire logic [2:0] clr_f = (wr && adr_i == `OFS_STS && sel_i[0]) ? ~dat_i[2:0] : 3'h0;

  inj_result_mem #(
    .W     (16),
    .DEPTH (4),
    .AW    (2)
  ) u_jmem (
    .clk_i   (clk_i),
    .we_i    (done && grp_inj),
    .waddr_i (pos[1:0]),
    .wdata_i ({4'h0, raw}),
    .raddr_i (2'(adr_i[7:2] - 6'h0B)),
    .rdata_o (mem_rdata)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flags   <= 3'h0;
      dat_reg <= 16'h0000;
    end
    else
    begin
      flags <= (flags & ~clr_f) | set_f;
      if (done && !grp_inj)
        dat_reg <= {4'h0, raw};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o        <= 1'b0;
      work_tick_o  <= 1'b0;
      power_on_o   <= 1'b0;
      deep_sleep_o <= 1'b0;
    end
    else
    begin
      irq_o        <= |(flags & {ctrl1[`C1_IEIE], ctrl1[`C1_REIE], ctrl1[`C1_GIE]});
      work_tick_o  <= wtick;
      power_on_o   <= st != adc_seq_pkg::PWR_OFF;
      deep_sleep_o <= st == adc_seq_pkg::PWR_OFF && ctrl3[`C3_DEEP];
    end
  end

  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_reg_done;
    done && !grp_inj;
  endsequence
  sequence s_inj_done;
    done && grp_inj;
  endsequence

  property p_tick_period;
    tick1m |-> ##TICK_P tick1m;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("timing tick period wrong");

  property p_wake_only;
    (st == adc_seq_pkg::PWR_OFF && on_wr && new_on) |=> st == adc_seq_pkg::PWR_STAB ##1 !conv_req_o.start;
  endproperty
  a_wake_only: assert property (p_wake_only) else $error("first on did not only wake");

  property p_power_down;
    (powered && off_req) |=> st == adc_seq_pkg::PWR_DOWN ##[1:PD_MAX] pd_done;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power down not reported");

  property p_deep_cal;
    $rose(pd_done) && ctrl3[`C3_DEEP] |-> !cal_valid;
  endproperty
  a_deep_cal: assert property (p_deep_cal) else $error("calibration kept in deep sleep");

  property p_reg_end;
    s_reg_done |=> flags[`ST_REND] && dat_reg[11:0] == $past(raw);
  endproperty
  a_reg_end: assert property (p_reg_end) else $error("regular end not recorded");

  property p_inj_end;
    s_inj_done |=> flags[`ST_IEND] && dat_reg == $past(dat_reg);
  endproperty
  a_inj_end: assert property (p_inj_end) else $error("injected end not recorded");

  property p_irq;
    (flags[`ST_REND] && ctrl1[`C1_REIE]) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled flag gave no interrupt");

  property p_guard_off;
    (s_reg_done and (!ctrl1[`C1_GREN] && !flags[`ST_TRIP] && !clr_f[0])) |=> !flags[`ST_TRIP];
  endproperty
  a_guard_off: assert property (p_guard_off) else $error("guard tripped while disabled");

  property p_single_stop;
    (seq_end && !grp_inj && !ctrl2[`C2_RPT] && !reg_pend && !sw_start && !r_edge) |=> !reg_pend;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single mode restarted");

  property p_repeat;
    (seq_end && !grp_inj && ctrl2[`C2_RPT]) |=> reg_pend ##1 st == adc_seq_pkg::PWR_CONV;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat mode did not rerun");
endmodule

// File: core_model.sv
// Behavioural converter core on the far side of the conversion link.
// Assumes one start pulse per conversion on clk_i, answered by one done.
module core_model #(
  parameter int DLY = 5
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire adc_seq_pkg::conv_req_t req_i,
  output adc_seq_pkg::conv_res_t      res_o,
  output int                          starts_o
);
  // ****************
  // Conversion answer
  // ****************
  logic [11:0] pend;
  int          cnt;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      res_o    <= '0;
      cnt      <= 0;
      starts_o <= 0;
      pend     <= 12'h000;
    end
    else
    begin
      // Data toggles outside done so a sample one cycle after done never matches
      res_o.done <= 1'b0;
      res_o.data <= ~res_o.data;
      if (req_i.start)
      begin
        // channel and group coded into data
        pend     <= {req_i.channel, req_i.injected, 6'h2A};
        cnt      <= DLY;
        starts_o <= starts_o + 1;
      end
      else if (cnt == 1)
      begin
        res_o.done <= 1'b1;
        res_o.data <= pend;
        cnt        <= 0;
      end
      else if (cnt > 1)
        cnt <= cnt - 1;
    end
  end
endmodule

// File: tb.sv
// Self-checking bench: Wishbone register tasks driving the sequencer.
// Assumes core_model answers each start after a short fixed delay.
`include "adc_seq_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   clk_i;
  logic                   rst_i;
  logic                   cyc;
  logic                   stb;
  logic                   we;
  logic [7:0]             adr;
  logic [3:0]             sel;
  logic [31:0]            wdat;
  logic [31:0]            rdat;
  logic [31:0]            q;
  logic                   ack;
  logic [7:0]             itrig;
  logic [7:0]             rtrig;
  logic                   wtk;
  logic [1:0]             pdiv = 2'h0;
  logic                   pwr;
  logic                   deep;
  logic                   irq;
  adc_seq_pkg::conv_req_t req;
  adc_seq_pkg::conv_res_t res;
  int                     starts;
  int                     error_cnt = 0;
  int                     checks_done = 0;
  int                     s0;
  int                     wcnt = 0;
  int                     wmin = 1000;

  adc_sequencer_control #(.STAB_US(1), .PDOWN_US(1)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .reg_trig_i(rtrig), .inj_trig_i(itrig), .pll_clk_i(pdiv[1]),
    .conv_res_i(res), .conv_req_o(req), .work_tick_o(wtk),
    .power_on_o(pwr), .deep_sleep_o(deep), .irq_o(irq));
  core_model i_core (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .res_o(res), .starts_o(starts));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ****************
  // PLL source and working-tick spacing
  // ****************
  always @(posedge clk_i)
    pdiv <= pdiv + 2'h1;

  always @(posedge clk_i)
  begin
    wcnt <= wtk ? 1 : wcnt + 1;
    if (wtk && wcnt < wmin)
      wmin <= wcnt;
  end

  // ****************
  // Bus and compare tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      error_cnt++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do
    begin
      wb(1'b0, a, 32'h0000_0000);
      n++;
    end
    while ((q & m) !== m && n < 300);
    chk(q & m, m);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    repeat (100) @(posedge clk_i);
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk_i);
    error_cnt++;
    finish_test();
  end

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    {cyc, stb, we, adr, sel, wdat, itrig, rtrig} = '0;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `OFS_WDGHI, 32'h0000_0000);
    chk(q, 32'h0000_0FFF);
    wb(1'b0, 8'hFC, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wb(1'b1, `OFS_CTRL2, 32'h0000_0001);
    poll(`OFS_CTRL3, 32'h0000_0001);
    chk({31'h0, pwr}, 32'h0000_0001);
    chk(32'(starts), 32'h0000_0000);
    // Two regular steps: temperature then op-amp one; one injected step
    // written while idle
    wb(1'b1, `OFS_RSEQ3, {22'h0, 5'h03, 5'h11});
    wb(1'b1, `OFS_RSEQ1, 32'h0010_0000);
    wb(1'b1, `OFS_JSEQ, 32'h0000_0012);
    wb(1'b1, `OFS_WDGHI, 32'h0000_00FF);
    wb(1'b1, `OFS_CTRL1, 32'h0080_00E0);
    wb(1'b1, `OFS_CTRL2, 32'h0008_0001);
    wait_irq();
    chk(32'(starts), 32'h0000_0002);
    wb(1'b0, `OFS_STS, 32'h0000_0000);
    chk(q, 32'h0000_0003);
    wb(1'b0, `OFS_DAT, 32'h0000_0000);
    chk(q, 32'h0000_01AA);
    chk({31'h0, irq}, 32'h0000_0001);
    wb(1'b1, `OFS_STS, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0000_0000);
    itrig <= 8'h01;
    repeat (6) @(posedge clk_i);
    itrig <= 8'h00;
    wait_irq();
    chk(32'(starts), 32'h0000_0003);
    wb(1'b0, `OFS_STS, 32'h0000_0000);
    chk(q, 32'h0000_0004);
    wb(1'b0, `OFS_JDAT0, 32'h0000_0000);
    chk(q, 32'h0000_096A);
    // Repeat with the regular guard off, then a single-channel guard
    wb(1'b1, `OFS_STS, 32'h0000_0000);
    wb(1'b1, `OFS_CTRL1, 32'h0000_00E0);
    wb(1'b1, `OFS_CTRL2, 32'h0008_0003);
    repeat (200) @(posedge clk_i);
    chk(32'(starts > 9), 32'h0000_0001);
    wb(1'b1, `OFS_CTRL1, 32'h0080_02E5);
    wb(1'b1, `OFS_CTRL2, 32'h0088_0001);
    repeat (200) @(posedge clk_i);
    s0 = starts;
    chk({31'h0, starts[0]}, 32'h0000_0001);
    wb(1'b0, `OFS_STS, 32'h0000_0000);
    chk(q, 32'h0000_0002);
    repeat (100) @(posedge clk_i);
    chk(32'(starts), 32'(s0));
    // PLL working clock, then a regular pin trigger, guard on channel 3
    wb(1'b1, `OFS_CTRL1, 32'h0080_02E3);
    wb(1'b1, `OFS_CTRL2, 32'h0088_1001);
    repeat (100) @(posedge clk_i);
    chk(32'(starts), 32'(s0 + 2));
    rtrig <= 8'h01;
    repeat (6) @(posedge clk_i);
    rtrig <= 8'h00;
    repeat (200) @(posedge clk_i);
    chk(32'(starts), 32'(s0 + 4));
    wb(1'b0, `OFS_STS, 32'h0000_0000);
    chk(q, 32'h0000_0003);
    chk(32'(wmin), 32'h0000_0002);
    wb(1'b1, `OFS_CTRL3, 32'h0000_000C);
    wb(1'b0, `OFS_CTRL3, 32'h0000_0000);
    chk(q, 32'h0000_000D);
    wb(1'b1, `OFS_CTRL2, 32'h0000_0000);
    poll(`OFS_CTRL3, 32'h0000_0002);
    chk(q, 32'h0000_0006);
    chk({31'h0, pwr}, 32'h0000_0000);
    chk({31'h0, deep}, 32'h0000_0001);
    finish_test();
  end
endmodule
